/* pkg/dem_pkg.sv */
// Purpose: constants, state type and helpers for the DSP execution monitor
// Assumes: 16-bit register bus at printed word offsets
// Notes: all reset values are zero
//
// What this block does
// - A software error captures the execute-stage program count into a 16-bit register.
// - A software error captures the instruction low 16 bits.
// - A software error captures the instruction high 16 bits.
// - Watchdog starts at reload value and decrements by one per counting tick.
// - Program restart for a new frame reloads the watchdog counter.
// - Watchdog reaching zero raises the watchdog error indication.
// - Reload field is 13 bits [12:0]; bits [15:13] reserved.
// - Timeout equals reload value times the selected prescale factor.
// - Prescale code 0 ticks every 64 cycles, doubling per step to 131072.
// - Enable bit 0 permits block interrupts; resets to 0.
// - Block frame counter increments on each frame-start pulse; 16-bit terminal.
// - At the terminal value a block interrupt fires and the counter restarts.
// - Current 24-bit program counter reads as high byte and low 16 bits.
// - While clear bit is 1 the program counter is held at zero.
// - Setting then clearing the clear bit resets the all-time peak record.
// - Peak program counter of the last frame is recorded, readable in two parts.
// - Watchdog error reaches the master flag only while its mask bit is 0.
// - Master error flag stays high until software clears it.
`default_nettype none
package dem_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [15:0] ADDR_EXEC_COUNT = 16'hf432;
   localparam logic [15:0] ADDR_INSTR_LOW = 16'hf433;
   localparam logic [15:0] ADDR_INSTR_HIGH = 16'hf434;
   localparam logic [15:0] ADDR_PANIC_CLEAR = 16'hf421;
   localparam logic [15:0] ADDR_WD_MASK = 16'hf424;
   localparam logic [15:0] ADDR_PANIC_FLAG = 16'hf427;
   localparam logic [15:0] ADDR_WD_RELOAD = 16'hf443;
   localparam logic [15:0] ADDR_WD_DIVIDER = 16'hf444;
   localparam logic [15:0] ADDR_BLK_ENABLE = 16'hf450;
   localparam logic [15:0] ADDR_BLK_TERMINAL = 16'hf451;
   localparam logic [15:0] ADDR_PC_HIGH = 16'hf460;
   localparam logic [15:0] ADDR_PC_LOW = 16'hf461;
   localparam logic [15:0] ADDR_PC_CLEAR = 16'hf462;
   localparam logic [15:0] ADDR_PEAK_HIGH = 16'hf463;
   localparam logic [15:0] ADDR_PEAK_LOW = 16'hf464;
   localparam logic [15:0] ADDR_ALLPEAK_HIGH = 16'hf465;
   localparam logic [15:0] ADDR_ALLPEAK_LOW = 16'hf466;
   // ----------------------------------------
   // Field layout and timing
   // ----------------------------------------
   localparam int RELOAD_W = 13;
   localparam int CODE_W = 4;
   localparam int PRE_W = 17;
   localparam int PC_W = 24;
   localparam logic [3:0] CODE_MAX = 4'hb;
   localparam logic [17:0] PRE_BASE = 18'h0_0040;
   localparam logic [15:0] RESET_VALUE = 16'h0000;

   typedef struct packed {
      logic [15:0] exec_count;
      logic [15:0] instr_low;
      logic [15:0] instr_high;
      logic [RELOAD_W-1:0] wd_reload;
      logic [CODE_W-1:0] wd_code;
      logic wd_mask;
      logic [RELOAD_W-1:0] wd_count;
      logic [PRE_W-1:0] pre_count;
      logic wd_armed;
      logic wd_error;
      logic panic_flag;
      logic panic_clear;
      logic blk_en;
      logic [15:0] blk_term;
      logic [15:0] blk_count;
      logic blk_irq;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] run_peak;
      logic [PC_W-1:0] frame_peak;
      logic [PC_W-1:0] all_peak;
      logic pc_clear;
      logic [15:0] rd_data;
   } dem_state_t;

   // Last prescaler count for a code; oversize codes clamp to the largest
   function automatic logic [PRE_W-1:0] dem_tick_last(input logic [CODE_W-1:0] code);
      logic [CODE_W-1:0] c;
      logic [17:0] p;
      c = (code > CODE_MAX) ? CODE_MAX : code;
      p = (PRE_BASE << c) - 18'h0_0001;
      return p[PRE_W-1:0];
   endfunction

   function automatic logic [PC_W-1:0] dem_max(input logic [PC_W-1:0] a,
                                                input logic [PC_W-1:0] b);
      return (a > b) ? a : b;
   endfunction
endpackage
`default_nettype wire

/* verilog/dem_monitor.sv */
// Purpose: DSP execution monitor: watchdog, block frame counter, PC tracking, error capture
// Assumes: core inputs are on ref_clk; one bus strobe at a time
// Notes: read data appear the cycle after the read strobe
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dem_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Core sequencer
   input wire logic [dem_pkg::PC_W-1:0] core_pc,
   input wire logic program_restart,
   input wire logic frame_start,
   input wire logic sw_error,
   input wire logic [15:0] core_exec_count,
   input wire logic [31:0] core_instr,
   // Indications
   output logic wd_error,
   output logic panic_flag,
   output logic block_irq
);
   import dem_pkg::*;

   dem_state_t s;
   dem_state_t next_s;

   logic wr_hit;
   logic tick;
   logic wd_expire;
   logic panic_clear_rise;
   logic [15:0] blk_next;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      next_s = s;
      wr_hit = reg_write;
      // At or past the last count, so a smaller code written mid-count cannot stall the tick
      tick = (s.pre_count >= dem_tick_last(s.wd_code));
      wd_expire = s.wd_armed && tick && (s.wd_count <= 13'h0001) && !program_restart;
      panic_clear_rise = 1'b0;
      blk_next = s.blk_count + 16'h0001;
      next_s.rd_data = RESET_VALUE;
      next_s.blk_irq = 1'b0;

      // Software writes
      if (wr_hit) begin
         unique case (reg_addr)
            ADDR_EXEC_COUNT: next_s.exec_count = reg_wdata;
            ADDR_INSTR_LOW: next_s.instr_low = reg_wdata;
            ADDR_INSTR_HIGH: next_s.instr_high = reg_wdata;
            ADDR_WD_RELOAD: next_s.wd_reload = reg_wdata[RELOAD_W-1:0];
            ADDR_WD_DIVIDER: next_s.wd_code = reg_wdata[CODE_W-1:0];
            ADDR_WD_MASK: next_s.wd_mask = reg_wdata[0];
            ADDR_PANIC_CLEAR: begin
               next_s.panic_clear = reg_wdata[0];
               panic_clear_rise = reg_wdata[0] && !s.panic_clear;
            end
            ADDR_BLK_ENABLE: next_s.blk_en = reg_wdata[0];
            ADDR_BLK_TERMINAL: next_s.blk_term = reg_wdata;
            ADDR_PC_CLEAR: next_s.pc_clear = reg_wdata[0];
            default: begin
            end
         endcase
      end

      // Reads, answered next cycle
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_EXEC_COUNT: next_s.rd_data = s.exec_count;
            ADDR_INSTR_LOW: next_s.rd_data = s.instr_low;
            ADDR_INSTR_HIGH: next_s.rd_data = s.instr_high;
            ADDR_WD_RELOAD: next_s.rd_data = {3'h0, s.wd_reload};
            ADDR_WD_DIVIDER: next_s.rd_data = {12'h000, s.wd_code};
            ADDR_WD_MASK: next_s.rd_data = {15'h0000, s.wd_mask};
            ADDR_PANIC_CLEAR: next_s.rd_data = {15'h0000, s.panic_clear};
            ADDR_PANIC_FLAG: next_s.rd_data = {15'h0000, s.panic_flag};
            ADDR_BLK_ENABLE: next_s.rd_data = {15'h0000, s.blk_en};
            ADDR_BLK_TERMINAL: next_s.rd_data = s.blk_term;
            ADDR_PC_HIGH: next_s.rd_data = {8'h00, s.pc[23:16]};
            ADDR_PC_LOW: next_s.rd_data = s.pc[15:0];
            ADDR_PC_CLEAR: next_s.rd_data = {15'h0000, s.pc_clear};
            ADDR_PEAK_HIGH: next_s.rd_data = {8'h00, s.frame_peak[23:16]};
            ADDR_PEAK_LOW: next_s.rd_data = s.frame_peak[15:0];
            ADDR_ALLPEAK_HIGH: next_s.rd_data = {8'h00, s.all_peak[23:16]};
            ADDR_ALLPEAK_LOW: next_s.rd_data = s.all_peak[15:0];
            default: next_s.rd_data = RESET_VALUE;
         endcase
      end

      // ----------------------------------------
      // Error capture, hardware wins over a write
      // ----------------------------------------
      if (sw_error) begin
         next_s.exec_count = core_exec_count;
         next_s.instr_low = core_instr[15:0];
         next_s.instr_high = core_instr[31:16];
      end

      // ----------------------------------------
      // Watchdog
      // ----------------------------------------
      if (program_restart) begin
         next_s.wd_count = s.wd_reload;
         next_s.pre_count = '0;
         next_s.wd_armed = 1'b1;
         next_s.wd_error = 1'b0;
      end else if (tick) begin
         next_s.pre_count = '0;
         if (wd_expire) begin
            next_s.wd_count = '0;
            next_s.wd_armed = 1'b0;
            next_s.wd_error = 1'b1;
         end else if (s.wd_armed) begin
            next_s.wd_count = s.wd_count - 13'h0001;
         end
      end else begin
         next_s.pre_count = s.pre_count + 17'h0_0001;
      end

      // Master flag: clear on a rising clear bit, a new error wins
      if (panic_clear_rise) begin
         next_s.panic_flag = 1'b0;
      end
      if (wd_expire && !s.wd_mask) begin
         next_s.panic_flag = 1'b1;
      end

      // ----------------------------------------
      // Block frame counter
      // ----------------------------------------
      if (frame_start && s.blk_en) begin
         if (blk_next == s.blk_term) begin
            next_s.blk_count = '0;
            next_s.blk_irq = 1'b1;
         end else begin
            next_s.blk_count = blk_next;
         end
      end else if (!s.blk_en) begin
         next_s.blk_count = '0;
      end

      // ----------------------------------------
      // Program counter and peaks
      // ----------------------------------------
      next_s.pc = s.pc_clear ? '0 : core_pc;
      if (s.pc_clear) begin
         next_s.run_peak = '0;
         next_s.frame_peak = '0;
      end else if (program_restart) begin
         next_s.frame_peak = dem_max(s.run_peak, s.pc);
         next_s.run_peak = '0;
      end else begin
         next_s.run_peak = dem_max(s.run_peak, s.pc);
      end
      if (s.pc_clear && !next_s.pc_clear) begin
         next_s.all_peak = '0;
      end else begin
         next_s.all_peak = dem_max(s.all_peak, s.pc);
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rd_data;
   assign wd_error = s.wd_error;
   assign panic_flag = s.panic_flag;
   assign block_irq = s.blk_irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence restart_s;
      program_restart;
   endsequence

   sequence expire_s;
      s.wd_armed && tick && (s.wd_count == 13'h0001) && !program_restart;
   endsequence

   sequence frame_end_s;
      frame_start && s.blk_en && (blk_next == s.blk_term);
   endsequence

   capture_exec_a: assert property (sw_error |=> s.exec_count == $past(core_exec_count))
      else $error("exec count not captured");
   capture_low_a: assert property (sw_error |=> s.instr_low == $past(core_instr[15:0]))
      else $error("instruction low not captured");
   capture_high_a: assert property (sw_error |=> s.instr_high == $past(core_instr[31:16]))
      else $error("instruction high not captured");
   wd_reload_a: assert property (restart_s |=> s.wd_count == $past(s.wd_reload)
                                 && s.pre_count == 17'h0_0000)
      else $error("watchdog not reloaded");
   wd_decrement_a: assert property (s.wd_armed && tick && s.wd_count > 13'h0001
                                    && !program_restart |=> s.wd_count == $past(s.wd_count) - 13'h0001)
      else $error("watchdog did not decrement");
   wd_hold_a: assert property (!tick && !program_restart |=> $stable(s.wd_count))
      else $error("watchdog moved without a tick");
   wd_tick_gap_a: assert property (restart_s ##1 (s.wd_code == 4'h0 && !program_restart) [*8]
                                   |=> s.pre_count == 17'h0_0008)
      else $error("prescaler pace wrong");
   wd_expire_a: assert property (expire_s |=> wd_error && s.wd_count == 13'h0000)
      else $error("watchdog error not raised");
   flag_report_a: assert property (expire_s and (!s.wd_mask) |=> panic_flag)
      else $error("unmasked watchdog error not flagged");
   flag_masked_a: assert property (expire_s and (s.wd_mask && !panic_flag) |=> !panic_flag)
      else $error("masked watchdog error flagged");
   flag_sticky_a: assert property (panic_flag && !(reg_write && reg_addr == ADDR_PANIC_CLEAR)
                                   |=> panic_flag)
      else $error("panic flag dropped");
   block_irq_a: assert property (frame_end_s |=> block_irq && s.blk_count == 16'h0000)
      else $error("block interrupt missing");
   block_off_a: assert property (!s.blk_en |=> !block_irq)
      else $error("block interrupt while disabled");
   pc_clear_a: assert property (s.pc_clear |=> s.pc == '0)
      else $error("program counter not held clear");
   peak_clear_a: assert property (s.pc_clear && !next_s.pc_clear |=> s.all_peak == '0)
      else $error("all-time peak not cleared");
endmodule // dem_monitor
`default_nettype wire

/* sim/dem_seq_model.sv */
// Purpose: behavioural sequencer and frame timing on the core side of the monitor
// Assumes: all outputs move just after a rising edge of ref_clk
// Notes: debug lines show the inverse value once a fault pulse is over
`timescale 1ns/1ps
`default_nettype none
module dem_seq_model (
   // Clock
   input wire logic ref_clk,
   // Sequencer outputs
   output logic [dem_pkg::PC_W-1:0] core_pc,
   output logic program_restart,
   output logic frame_start,
   output logic sw_error,
   output logic [15:0] core_exec_count,
   output logic [31:0] core_instr
);
   import dem_pkg::*;
   initial begin
      core_pc = 24'h00_0000;
      program_restart = 1'b0;
      frame_start = 1'b0;
      sw_error = 1'b0;
      core_exec_count = 16'h0000;
      core_instr = 32'h0000_0000;
   end
   task automatic restart();
      @(posedge ref_clk);
      program_restart <= 1'b1;
      @(posedge ref_clk);
      program_restart <= 1'b0;
   endtask
   // Back to back frame pulses, n of them
   task automatic frames(input int n);
      @(posedge ref_clk);
      frame_start <= 1'b1;
      repeat (n) @(posedge ref_clk);
      frame_start <= 1'b0;
   endtask
   task automatic fault(input logic [15:0] cnt, input logic [31:0] ins);
      @(posedge ref_clk);
      sw_error <= 1'b1;
      core_exec_count <= cnt;
      core_instr <= ins;
      @(posedge ref_clk);
      sw_error <= 1'b0;
      core_exec_count <= ~cnt;
      core_instr <= ~ins;
   endtask
   task automatic set_pc(input logic [PC_W-1:0] v);
      @(posedge ref_clk);
      core_pc <= v;
   endtask
endmodule // dem_seq_model
`default_nettype wire

/* sim/tb.sv */
// Purpose: self-checking bench for the execution monitor
// Assumes: sequencer model drives the core side
// Notes: watchdog runs use short prescale codes to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dem_pkg::*;
   localparam int LIMIT = 20000;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic [PC_W-1:0] core_pc;
   logic program_restart, frame_start, sw_error;
   logic [15:0] core_exec_count;
   logic [31:0] core_instr;
   logic wd_error, panic_flag, block_irq;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;
   int irq_n = 0;
   logic [15:0] tbl [13] = '{ADDR_EXEC_COUNT, ADDR_INSTR_LOW, ADDR_INSTR_HIGH, ADDR_WD_RELOAD,
      ADDR_WD_DIVIDER, ADDR_BLK_ENABLE, ADDR_BLK_TERMINAL, ADDR_PC_HIGH, ADDR_PC_LOW,
      ADDR_PC_CLEAR, ADDR_PEAK_HIGH, ADDR_PEAK_LOW, ADDR_ALLPEAK_LOW};

   dem_monitor dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .core_pc(core_pc), .program_restart(program_restart),
      .frame_start(frame_start), .sw_error(sw_error), .core_exec_count(core_exec_count),
      .core_instr(core_instr), .wd_error(wd_error), .panic_flag(panic_flag),
      .block_irq(block_irq));
   dem_seq_model core_u (.ref_clk(ref_clk), .core_pc(core_pc),
      .program_restart(program_restart), .frame_start(frame_start), .sw_error(sw_error),
      .core_exec_count(core_exec_count), .core_instr(core_instr));

   always #5 ref_clk = ~ref_clk;
   // Cycle ceiling and interrupt pulse count
   always @(posedge ref_clk) begin
      cycles++;
      if (block_irq === 1'b1) irq_n++;
      if (cycles == LIMIT) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      chk16(reg_rdata, exp);
   endtask
   // Cycles from the restart edge until the watchdog error shows
   task automatic wd_time(input logic [3:0] code, input logic [15:0] rel,
                          input logic [15:0] exp);
      int n;
      wr(ADDR_WD_DIVIDER, {12'h000, code});
      wr(ADDR_WD_RELOAD, rel);
      core_u.restart();
      n = 0;
      #1;
      while (wd_error !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
         #1;
      end
      chk16(16'(n), exp);
   endtask
   task automatic frame_irqs(input int n, input logic [15:0] exp);
      irq_n = 0;
      core_u.frames(n);
      repeat (3) @(posedge ref_clk);
      #1;
      chk16(16'(irq_n), exp);
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (tbl[i]) rd_chk(tbl[i], 16'h0000);
      rd_chk(16'hf470, 16'h0000);
      wr(ADDR_WD_RELOAD, 16'h1abc);
      rd_chk(ADDR_WD_RELOAD, 16'h1abc);
      wr(ADDR_WD_DIVIDER, 16'h000b);
      rd_chk(ADDR_WD_DIVIDER, 16'h000b);
      wr(ADDR_BLK_ENABLE, 16'h0001);
      rd_chk(ADDR_BLK_ENABLE, 16'h0001);
      wr(ADDR_BLK_TERMINAL, 16'hbeef);
      rd_chk(ADDR_BLK_TERMINAL, 16'hbeef);
      $display("test registers done");
      core_u.fault(16'h1234, 32'hdead_beef);
      rd_chk(ADDR_EXEC_COUNT, 16'h1234);
      rd_chk(ADDR_INSTR_LOW, 16'hbeef);
      rd_chk(ADDR_INSTR_HIGH, 16'hdead);
      $display("test capture done");
      // Expected cycles are the reload times the prescale factor of each run
      wd_time(4'h0, 16'h0002, 16'h0080);
      chk1(panic_flag, 1'b1);
      core_u.restart();
      #1;
      chk1(wd_error, 1'b0);
      chk1(panic_flag, 1'b1);
      repeat (100) @(posedge ref_clk);
      wd_time(4'h0, 16'h0002, 16'h0080);
      wr(ADDR_PANIC_CLEAR, 16'h0000);
      wr(ADDR_PANIC_CLEAR, 16'h0001);
      rd_chk(ADDR_PANIC_FLAG, 16'h0000);
      wr(ADDR_WD_MASK, 16'h0001);
      wd_time(4'h1, 16'h0001, 16'h0080);
      chk1(panic_flag, 1'b0);
      wd_time(4'h2, 16'h0001, 16'h0100);
      wd_time(4'h0, 16'h0003, 16'h00c0);
      $display("test watchdog done");
      wr(ADDR_BLK_TERMINAL, 16'h0003);
      frame_irqs(6, 16'h0002);
      wr(ADDR_BLK_ENABLE, 16'h0000);
      frame_irqs(4, 16'h0000);
      wr(ADDR_BLK_ENABLE, 16'h0001);
      wr(ADDR_BLK_TERMINAL, 16'h0001);
      frame_irqs(3, 16'h0003);
      $display("test block done");
      core_u.set_pc(24'h05_0200);
      core_u.set_pc(24'h12_3456);
      rd_chk(ADDR_PC_HIGH, 16'h0012);
      rd_chk(ADDR_PC_LOW, 16'h3456);
      core_u.set_pc(24'h00_0010);
      core_u.restart();
      rd_chk(ADDR_PEAK_HIGH, 16'h0012);
      rd_chk(ADDR_PEAK_LOW, 16'h3456);
      rd_chk(ADDR_ALLPEAK_LOW, 16'h3456);
      wr(ADDR_PC_CLEAR, 16'h0001);
      rd_chk(ADDR_PC_LOW, 16'h0000);
      rd_chk(ADDR_PEAK_LOW, 16'h0000);
      core_u.set_pc(24'h00_0000);
      wr(ADDR_PC_CLEAR, 16'h0000);
      rd_chk(ADDR_ALLPEAK_HIGH, 16'h0000);
      rd_chk(ADDR_ALLPEAK_LOW, 16'h0000);
      $display("test program counter done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
